// >>> pkg/fbw_pkg.sv
package fbw_pkg;
	// Flash geometry
	localparam int ADDR_W = 17;
	localparam int PAGE_SHIFT = 10;
	localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
	localparam logic [ADDR_W-1:0] LOCK_BYTE_ADDR = 17'h1fbff;
	localparam logic [ADDR_W-1:0] RESV_BASE_ADDR = 17'h1fc00;
	localparam logic [ADDR_W-1:0] MOVX8_LIMIT = 17'h000ff;
	// Key codes
	localparam logic [7:0] KEY_FIRST = 8'ha5;
	localparam logic [7:0] KEY_SECOND = 8'hf1;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// Block-write lane positions
	localparam logic [1:0] LANE_LAST = 2'h3;
	localparam int BLOCK_BYTES = 4;
	// Reset values
	localparam logic [7:0] LOCK_RST = 8'hff;
	localparam logic [1:0] KEY_RST = 2'h0;
	// Source of an access
	typedef enum logic [1:0] {
		FBW_SRC_DEBUG,
		FBW_SRC_CODE_UNLOCKED,
		FBW_SRC_CODE_LOCKED
	} fbw_src_type;
	// Operation kind
	typedef enum logic [1:0] {
		FBW_OP_READ,
		FBW_OP_WRITE,
		FBW_OP_ERASE,
		FBW_OP_DEV_ERASE
	} fbw_op_type;
	// Verdict of the checker
	typedef enum logic [1:0] {
		FBW_OK,
		FBW_IGNORE,
		FBW_FERR
	} fbw_verdict_type;
endpackage

// >>> core/fbw_sec_check.sv
`timescale 1ns/10ps
// Page-lock checker: combinational verdict for one access
module fbw_sec_check (
	input  wire logic [7:0]                   lock_byte_in,
	input  wire logic [fbw_pkg::ADDR_W-1:0]   addr_in,
	input  wire fbw_pkg::fbw_op_type          op_in,
	input  wire fbw_pkg::fbw_src_type         src_in,
	input  wire logic                         lock_change_in,
	output fbw_pkg::fbw_verdict_type          verdict_out
);
	logic [7:0]                 n_locked;
	logic [fbw_pkg::PAGE_W-1:0] page;
	logic [fbw_pkg::PAGE_W-1:0] lock_page;
	logic                       any_locked;
	logic                       is_resv;
	logic                       is_lock_page;
	logic                       page_locked;
	logic                       dbg;

	// Decode of the page map
	assign n_locked     = ~lock_byte_in;
	assign any_locked   = (lock_byte_in != fbw_pkg::LOCK_RST);
	assign page         = addr_in[fbw_pkg::ADDR_W-1:fbw_pkg::PAGE_SHIFT];
	assign lock_page    = fbw_pkg::LOCK_BYTE_ADDR[fbw_pkg::ADDR_W-1:fbw_pkg::PAGE_SHIFT];
	assign is_resv      = (addr_in >= fbw_pkg::RESV_BASE_ADDR);
	assign is_lock_page = (page == lock_page);
	assign page_locked  = ({1'b0, page} < n_locked);
	assign dbg          = (src_in == fbw_pkg::FBW_SRC_DEBUG);

	// Priority: device erase, reserved area, lock byte change, lock page, other pages
	always_comb begin
		verdict_out = fbw_pkg::FBW_OK;
		if (op_in == fbw_pkg::FBW_OP_DEV_ERASE) begin
			verdict_out = dbg ? fbw_pkg::FBW_OK : fbw_pkg::FBW_IGNORE;
		end else if (is_resv) begin
			verdict_out = dbg ? fbw_pkg::FBW_IGNORE : fbw_pkg::FBW_FERR;
		end else if (lock_change_in) begin
			verdict_out = dbg ? fbw_pkg::FBW_IGNORE : fbw_pkg::FBW_FERR;
		end else if (is_lock_page && op_in == fbw_pkg::FBW_OP_ERASE) begin
			if (!dbg)
				verdict_out = fbw_pkg::FBW_FERR;
			else if (any_locked)
				verdict_out = fbw_pkg::FBW_IGNORE;
		end else if ((is_lock_page && any_locked) || (!is_lock_page && page_locked)) begin
			// Locked page: only code running from a locked page may touch it
			case (src_in)
				fbw_pkg::FBW_SRC_DEBUG:         verdict_out = fbw_pkg::FBW_IGNORE;
				fbw_pkg::FBW_SRC_CODE_UNLOCKED: verdict_out = fbw_pkg::FBW_FERR;
				default:                        verdict_out = fbw_pkg::FBW_OK;
			endcase
		end
	end
endmodule

// >>> core/fbw_flash_ctrl.sv
`timescale 1ns/10ps
module fbw_flash_ctrl (
	input  wire logic                       ref_clk_in,
	input  wire logic                       sys_rst_in,
	// Control bits
	input  wire logic                       block_write_enable_in,
	input  wire logic                       store_write_enable_in,
	input  wire logic                       store_erase_enable_in,
	input  wire logic                       supply_mon_ok_in,
	// Key register write
	input  wire logic                       key_wr_in,
	input  wire logic [7:0]                 key_data_in,
	// Access request from core or debug port
	input  wire logic                       req_in,
	input  wire fbw_pkg::fbw_op_type        req_op_in,
	input  wire fbw_pkg::fbw_src_type       req_src_in,
	input  wire logic                       req_movx8_in,
	input  wire logic                       req_external_move_instr_read_in,
	input  wire logic [fbw_pkg::ADDR_W-1:0] req_addr_in,
	input  wire logic [7:0]                 req_data_in,
	input  wire logic [7:0]                 req_old_in,
	// Lock byte value as stored in the array
	input  wire logic [7:0]                 lock_byte_in,
	// Flash array commands, then request and error status
	output logic                            fl_prog_out,
	output logic [fbw_pkg::ADDR_W-1:0]      fl_addr_out,
	output logic [31:0]                     fl_data_out,
	output logic [3:0]                      fl_lane_en_out,
	output logic                            fl_erase_out,
	output logic                            fl_dev_erase_out,
	output logic                            req_done_out,
	output logic                            req_ignored_out,
	output logic                            flash_error_flag_out,
	output logic                            ferr_reset_out,
	output logic                            key_locked_out
);
	logic [7:0]                  lock_eff_ff;
	logic [1:0]                  key_state_ff;
	logic                        key_dead_ff;
	logic [7:0]                  cache_ff [0:fbw_pkg::BLOCK_BYTES-2];
	logic [2:0]                  cache_vld_ff;
	logic                        prog_ff;
	logic [fbw_pkg::ADDR_W-1:0]  addr_ff;
	logic [31:0]                 data_ff;
	logic [3:0]                  lane_ff;
	logic                        erase_ff;
	logic                        dev_erase_ff;
	logic                        done_ff;
	logic                        ign_ff;
	logic                        ferr_ff;
	logic                        ferr_flag_ff;
	logic                        ferr_rst_ff;
	logic                        rst_q_ff;
	fbw_pkg::fbw_verdict_type    verdict;
	logic                        lock_change;
	logic                        is_lock_byte;
	logic                        is_mod;
	logic                        key_ok;
	logic                        enable_ok;
	logic                        do_op;
	logic                        ferr_now;
	logic [1:0]                  lane;
	logic                        dbg;
	logic [7:0]                  prog_val;

	assign dbg          = (req_src_in == fbw_pkg::FBW_SRC_DEBUG);
	assign lane         = req_addr_in[1:0];
	assign is_lock_byte = (req_addr_in == fbw_pkg::LOCK_BYTE_ADDR);
	assign is_mod       = (req_op_in == fbw_pkg::FBW_OP_WRITE) || (req_op_in == fbw_pkg::FBW_OP_ERASE);
	// Any write to a lock byte already holding zeros counts as a change
	assign lock_change  = is_lock_byte && (req_op_in == fbw_pkg::FBW_OP_WRITE)
		&& (lock_byte_in != fbw_pkg::LOCK_RST);

	// Page locks are judged on the latched lock byte; only the lock byte change test uses the live array value
	fbw_sec_check u_sec (
		.lock_byte_in   (lock_eff_ff),
		.addr_in        (req_addr_in),
		.op_in          (req_op_in),
		.src_in         (req_src_in),
		.lock_change_in (lock_change),
		.verdict_out    (verdict)
	);

	// Firmware needs the enables and a fresh key; debug port does not
	assign key_ok    = dbg || ((key_state_ff == 2'h2) && !key_dead_ff);
	assign enable_ok = dbg || (store_write_enable_in
		&& ((req_op_in != fbw_pkg::FBW_OP_ERASE) || store_erase_enable_in));
	// Forbidden reads reset the device too; the supply check guards only modifications
	assign ferr_now  = req_in && !dbg && !req_external_move_instr_read_in
		&& ((verdict == fbw_pkg::FBW_FERR) || (is_mod && !supply_mon_ok_in));
	assign do_op     = req_in && !ferr_now && !req_external_move_instr_read_in
		&& (verdict == fbw_pkg::FBW_OK)
		&& (req_op_in == fbw_pkg::FBW_OP_DEV_ERASE
			|| (is_mod && key_ok && enable_ok
				&& !(req_movx8_in && req_addr_in > fbw_pkg::MOVX8_LIMIT)));
	// Program only clears bits
	assign prog_val  = req_data_in & req_old_in;

	// Lock byte is sampled once per reset so user writes wait for next reset
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in)
			lock_eff_ff <= lock_byte_in;
		else if (fl_dev_erase_out)
			lock_eff_ff <= fbw_pkg::LOCK_RST;
	end

	// Key sequencer: 0 idle, 1 saw first code, 2 armed
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			key_state_ff <= fbw_pkg::KEY_RST;
			key_dead_ff  <= 1'b0;
		end else if (key_wr_in) begin
			if (key_state_ff == 2'h0 && key_data_in == fbw_pkg::KEY_FIRST)
				key_state_ff <= 2'h1;
			else if (key_state_ff == 2'h1 && key_data_in == fbw_pkg::KEY_SECOND)
				key_state_ff <= 2'h2;
			else
				key_dead_ff <= 1'b1;
		end else if (req_in && is_mod && !dbg) begin
			if (key_state_ff != 2'h2)
				key_dead_ff <= 1'b1;
			key_state_ff <= fbw_pkg::KEY_RST;
		end
	end

	// Block cache for lanes 00b to 10b
	genvar g;
	generate
		for (g = 0; g < fbw_pkg::BLOCK_BYTES - 1; g++) begin : g_cache
			always_ff @(posedge ref_clk_in) begin
				if (sys_rst_in || !block_write_enable_in) begin
					cache_vld_ff[g] <= 1'b0;
					cache_ff[g]     <= fbw_pkg::ERASED_BYTE;
				end else if (do_op && req_op_in == fbw_pkg::FBW_OP_WRITE) begin
					if (lane == fbw_pkg::LANE_LAST) begin
						cache_vld_ff[g] <= 1'b0;
					end else if (lane == 2'(g)) begin
						cache_vld_ff[g] <= 1'b1;
						cache_ff[g]     <= prog_val;
					end
				end
			end
		end
	endgenerate

	// Array command issue: one cycle per program or erase
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			prog_ff      <= 1'b0;
			erase_ff     <= 1'b0;
			dev_erase_ff <= 1'b0;
			addr_ff      <= '0;
			data_ff      <= 32'hffffffff;
			lane_ff      <= 4'h0;
		end else begin
			prog_ff      <= 1'b0;
			erase_ff     <= 1'b0;
			dev_erase_ff <= 1'b0;
			if (do_op) begin
				addr_ff <= req_addr_in;
				case (req_op_in)
					fbw_pkg::FBW_OP_WRITE: begin
						if (!block_write_enable_in) begin
							prog_ff <= 1'b1;
							lane_ff <= 4'h1 << lane;
							data_ff <= {4{prog_val}};
						end else if (lane == fbw_pkg::LANE_LAST) begin
							prog_ff <= 1'b1;
							addr_ff <= {req_addr_in[fbw_pkg::ADDR_W-1:2], 2'h0};
							lane_ff <= {1'b1, cache_vld_ff};
							data_ff <= {prog_val, cache_ff[2], cache_ff[1], cache_ff[0]};
						end
						// Lower lanes only fill the cache, nothing reaches the array
					end
					fbw_pkg::FBW_OP_ERASE: begin
						erase_ff <= 1'b1;
						addr_ff  <= {req_addr_in[fbw_pkg::ADDR_W-1:fbw_pkg::PAGE_SHIFT],
							10'h000};
					end
					fbw_pkg::FBW_OP_DEV_ERASE: begin
						dev_erase_ff <= 1'b1;
					end
					default: begin
						prog_ff <= 1'b0;
					end
				endcase
			end
		end
	end

	// Completion and refusal strobes
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			done_ff <= 1'b0;
			ign_ff  <= 1'b0;
		end else begin
			done_ff <= do_op;
			ign_ff  <= req_in && !do_op && !ferr_now;
		end
	end

	// Flash error: pending bit carries the cause across the reset it requests
	always_ff @(posedge ref_clk_in) begin
		ferr_rst_ff <= ferr_now && !sys_rst_in;
		rst_q_ff    <= sys_rst_in;
		if (ferr_rst_ff)
			ferr_ff <= 1'b1;
		else if (!sys_rst_in && rst_q_ff)
			ferr_ff <= 1'b0; // Cause consumed once the reset is over
		if (ferr_rst_ff)
			ferr_flag_ff <= 1'b1;
		else if (sys_rst_in)
			ferr_flag_ff <= ferr_ff;
	end

	assign fl_prog_out          = prog_ff;
	assign fl_addr_out          = addr_ff;
	assign fl_data_out          = data_ff;
	assign fl_lane_en_out       = lane_ff;
	assign fl_erase_out         = erase_ff;
	assign fl_dev_erase_out     = dev_erase_ff;
	assign req_done_out         = done_ff;
	assign req_ignored_out      = ign_ff;
	assign flash_error_flag_out = ferr_flag_ff;
	assign ferr_reset_out       = ferr_rst_ff;
	assign key_locked_out       = key_dead_ff;

	// Assertions
	a_key_rearm: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(req_in && is_mod && !dbg) |=> (key_state_ff == 2'h0))
		else $error("key did not rearm");
	a_key_dead: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		key_dead_ff |=> !(fl_prog_out && $past(!dbg)))
		else $error("write after key lockout");
	a_no_partial: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(do_op && block_write_enable_in && req_op_in == fbw_pkg::FBW_OP_WRITE
			&& lane != fbw_pkg::LANE_LAST) |=> !fl_prog_out)
		else $error("partial block programmed");
	a_blk_commit: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(do_op && block_write_enable_in && req_op_in == fbw_pkg::FBW_OP_WRITE
			&& lane == fbw_pkg::LANE_LAST) |=> (fl_prog_out && fl_lane_en_out[3]
			&& fl_addr_out[1:0] == 2'h0))
		else $error("block not committed");
	a_erase_en: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(fl_erase_out) |-> $past(dbg || (store_erase_enable_in && store_write_enable_in)))
		else $error("erase without enables");
	a_movx8_lim: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(req_in && req_movx8_in && req_addr_in > fbw_pkg::MOVX8_LIMIT) |=> !fl_prog_out
			&& !fl_erase_out)
		else $error("movx8 reached high flash");
	a_dbg_noreset: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(req_in && dbg) |=> !ferr_reset_out)
		else $error("debug caused reset");
	a_supply_ferr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(req_in && is_mod && !dbg && !req_external_move_instr_read_in && !supply_mon_ok_in)
		|=> ferr_reset_out ##1 flash_error_flag_out)
		else $error("supply fault not reset");
	a_external_move_instr_read: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(req_in && req_external_move_instr_read_in) |=> !req_done_out)
		else $error("external_move_instr read reached flash");
endmodule

// >>> tb/fbw_flash_model.sv
`timescale 1ns/10ps
// Behavioural flash array seen by the controller's command outputs
module fbw_flash_model (
	input  wire logic        ref_clk_in,
	input  wire logic        prog_in,
	input  wire logic [16:0] addr_in,
	input  wire logic [31:0] data_in,
	input  wire logic [3:0]  lane_en_in,
	input  wire logic        erase_in,
	input  wire logic        dev_erase_in,
	input  wire logic [16:0] rd_addr_in,
	output logic      [7:0]  rd_data_out,
	output logic      [7:0]  lock_byte_out
);
	logic [7:0] mem_ff [0:131071];
	// Blank array at power-up, as a fresh part would be
	initial begin
		for (int i = 0; i < 131072; i++) mem_ff[i] = 8'hff;
	end
	// Programming only clears bits; erase restores whole page or whole array
	always @(posedge ref_clk_in) begin
		if (prog_in) begin
			for (int i = 0; i < 4; i++) begin
				if (lane_en_in[i]) mem_ff[{addr_in[16:2], i[1:0]}] &= data_in[8*i +: 8];
			end
		end
		if (erase_in) begin
			for (int j = 0; j < 1024; j++) mem_ff[{addr_in[16:10], j[9:0]}] = 8'hff;
		end
		if (dev_erase_in) begin
			for (int i = 0; i < 131072; i++) mem_ff[i] = 8'hff;
		end
	end
	// Old byte is combinational so the controller can merge in the same cycle
	assign rd_data_out = mem_ff[rd_addr_in];
	assign lock_byte_out = mem_ff[fbw_pkg::LOCK_BYTE_ADDR];
endmodule

// >>> tb/flash_block_write_and_security_tb.sv
`timescale 1ns/10ps
module flash_block_write_and_security_tb;
	logic                  ref_clk_in = 1'b0;
	logic                  sys_rst_in = 1'b1;
	logic                  bw_en = 1'b0, sw_en = 1'b0, se_en = 1'b0, sup_ok = 1'b1;
	logic                  key_wr = 1'b0, req = 1'b0, m8 = 1'b0, mrd = 1'b0;
	logic [7:0]            key_data = 8'h00, req_data = 8'h00, old_b, lock_b;
	logic [16:0]           req_addr = 17'h00000;
	fbw_pkg::fbw_op_type   req_op = fbw_pkg::FBW_OP_READ;
	fbw_pkg::fbw_src_type  req_src = fbw_pkg::FBW_SRC_DEBUG;
	logic                  prog, erase, dev_erase, done, ign, flag, ferr, klock;
	logic [16:0]           fl_addr;
	logic [31:0]           fl_data;
	logic [3:0]            lanes;
	logic [2:0]            rsp, str;
	int                    n_errors = 0, total_checks = 0, cycles = 0;

	fbw_flash_ctrl i_fbw_flash_ctrl (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.block_write_enable_in(bw_en), .store_write_enable_in(sw_en),
		.store_erase_enable_in(se_en), .supply_mon_ok_in(sup_ok), .key_wr_in(key_wr),
		.key_data_in(key_data), .req_in(req), .req_op_in(req_op), .req_src_in(req_src),
		.req_movx8_in(m8), .req_external_move_instr_read_in(mrd), .req_addr_in(req_addr),
		.req_data_in(req_data), .req_old_in(old_b), .lock_byte_in(lock_b),
		.fl_prog_out(prog), .fl_addr_out(fl_addr), .fl_data_out(fl_data),
		.fl_lane_en_out(lanes), .fl_erase_out(erase), .fl_dev_erase_out(dev_erase),
		.req_done_out(done), .req_ignored_out(ign), .flash_error_flag_out(flag),
		.ferr_reset_out(ferr), .key_locked_out(klock));
	fbw_flash_model i_fbw_flash_model (.ref_clk_in(ref_clk_in), .prog_in(prog),
		.addr_in(fl_addr), .data_in(fl_data), .lane_en_in(lanes), .erase_in(erase),
		.dev_erase_in(dev_erase), .rd_addr_in(req_addr), .rd_data_out(old_b),
		.lock_byte_out(lock_b));

	// Clock, plus a cycle ceiling that ends a hung run
	initial begin
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic rst();
		@(posedge ref_clk_in) sys_rst_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
	endtask
	task automatic en(input logic b, input logic w, input logic e, input logic s);
		@(posedge ref_clk_in) {bw_en, sw_en, se_en, sup_ok} <= {b, w, e, s};
	endtask
	task automatic key1(input logic [7:0] d);
		@(posedge ref_clk_in) begin key_wr <= 1'b1; key_data <= d; end
		@(posedge ref_clk_in) key_wr <= 1'b0;
	endtask
	// One access; key pair first when asked, results captured once settled
	task automatic acc(input fbw_pkg::fbw_op_type op, input fbw_pkg::fbw_src_type src,
		input logic [16:0] a, input logic [7:0] d, input logic k);
		if (k) begin key1(fbw_pkg::KEY_FIRST); key1(fbw_pkg::KEY_SECOND); end
		@(posedge ref_clk_in) begin
			req <= 1'b1; req_op <= op; req_src <= src; req_addr <= a; req_data <= d;
		end
		@(posedge ref_clk_in) req <= 1'b0;
		@(negedge ref_clk_in) begin rsp = {done, ign, ferr}; str = {prog, erase, dev_erase}; end
	endtask

	// Block mode: three lanes cached, fourth commits all at once
	task automatic t_block();
		en(1'b1, 1'b1, 1'b0, 1'b1);
		for (int i = 0; i < 3; i++) begin
			acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00400 + i, 8'h11 * (i + 1), 1'b1);
			chk("cached lane no program", str[2], 1'b0);
		end
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00403, 8'h44, 1'b1);
		chk("commit strobe", {str[2], rsp[2]}, 2'h3);
		chk("commit lanes", lanes, 4'hf);
		@(negedge ref_clk_in);
		for (int i = 0; i < 4; i++) chk("block byte", i_fbw_flash_model.mem_ff[17'h00400 + i], 8'h11 * (i + 1));
	endtask
	// Abandoned block never lands; later single writes only clear bits
	task automatic t_abort();
		for (int i = 0; i < 3; i++) acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00410 + i, 8'h55, 1'b1);
		en(1'b0, 1'b1, 1'b0, 1'b1);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00413, 8'h66, 1'b1);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00413, 8'h0f, 1'b1);
		@(negedge ref_clk_in);
		chk("stale cache dropped", i_fbw_flash_model.mem_ff[17'h00410], 8'hff);
		chk("stale lane2 dropped", i_fbw_flash_model.mem_ff[17'h00412], 8'hff);
		chk("write clears only", i_fbw_flash_model.mem_ff[17'h00413], 8'h06);
	endtask
	// Key rearm, key lockout, enables, supply monitor and error flag
	task automatic t_keys_enables();
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00414, 8'h00, 1'b0);
		chk("no key refused", {rsp, str}, 6'b010000);
		rst();
		key1(fbw_pkg::KEY_SECOND);
		key1(fbw_pkg::KEY_FIRST);
		@(negedge ref_clk_in) chk("key lockout", klock, 1'b1);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00414, 8'h00, 1'b1);
		chk("locked out write", {rsp, str}, 6'b010000);
		rst();
		chk("lockout cleared", klock, 1'b0);
		en(1'b0, 1'b0, 1'b0, 1'b1);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00805, 8'h00, 1'b1);
		chk("write without enable", {rsp, str}, 6'b010000);
		en(1'b0, 1'b1, 1'b0, 1'b1);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00805, 8'h00, 1'b1);
		acc(fbw_pkg::FBW_OP_ERASE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00805, 8'h00, 1'b1);
		chk("erase without erase enable", {rsp, str}, 6'b010000);
		en(1'b0, 1'b1, 1'b1, 1'b1);
		acc(fbw_pkg::FBW_OP_ERASE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00805, 8'h00, 1'b1);
		chk("erase strobe", {rsp, str}, 6'b100010);
		@(negedge ref_clk_in) chk("page erased", i_fbw_flash_model.mem_ff[17'h00805], 8'hff);
		en(1'b0, 1'b1, 1'b0, 1'b0);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00806, 8'h00, 1'b1);
		chk("supply off reset", {rsp[0], str}, 4'b1000);
		rst();
		chk("error flag set", flag, 1'b1);
		rst();
		chk("error flag clean", flag, 1'b0);
	endtask
	// Narrow external-move limit and external-move reads never reach the array
	task automatic t_external_move_instr();
		en(1'b0, 1'b1, 1'b0, 1'b1);
		@(posedge ref_clk_in) m8 <= 1'b1;
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00100, 8'h00, 1'b1);
		chk("narrow above limit", {rsp, str}, 6'b010000);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h000ff, 8'h00, 1'b1);
		chk("narrow at limit", {rsp[2], str[2]}, 2'h3);
		@(posedge ref_clk_in) begin m8 <= 1'b0; mrd <= 1'b1; end
		acc(fbw_pkg::FBW_OP_READ, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00400, 8'h00, 1'b0);
		chk("ext read to ram", {rsp, str}, 6'b010000);
		@(posedge ref_clk_in) mrd <= 1'b0;
	endtask
	// Lock byte 0xfd: pages 0,1 and the lock page locked after the next reset
	task automatic t_security();
		en(1'b0, 1'b1, 1'b1, 1'b1);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_UNLOCKED, fbw_pkg::LOCK_BYTE_ADDR, 8'hfd, 1'b1);
		chk("lock byte first write", rsp, 3'b100);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_DEBUG, 17'h00010, 8'h00, 1'b0);
		chk("lock not yet active", rsp, 3'b100);
		rst();
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_DEBUG, 17'h00011, 8'h00, 1'b0);
		chk("debug locked page", {rsp, str}, 6'b010000);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_UNLOCKED, 17'h00020, 8'h00, 1'b1);
		chk("unlocked code locked page", rsp[0], 1'b1);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h00420, 8'h00, 1'b1);
		chk("locked code page 1", rsp, 3'b100);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_UNLOCKED, 17'h00820, 8'h00, 1'b1);
		chk("page 2 unlocked", rsp, 3'b100);
		acc(fbw_pkg::FBW_OP_READ, fbw_pkg::FBW_SRC_DEBUG, fbw_pkg::LOCK_BYTE_ADDR, 8'h00, 1'b0);
		chk("debug lock byte read", rsp, 3'b010);
		acc(fbw_pkg::FBW_OP_READ, fbw_pkg::FBW_SRC_CODE_UNLOCKED, 17'h1fb00, 8'h00, 1'b0);
		chk("unlocked code lock page", rsp[0], 1'b1);
		acc(fbw_pkg::FBW_OP_ERASE, fbw_pkg::FBW_SRC_CODE_LOCKED, 17'h1fb00, 8'h00, 1'b1);
		chk("fw lock page erase", {rsp[0], str}, 4'b1000);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_CODE_LOCKED, fbw_pkg::LOCK_BYTE_ADDR, 8'hfc, 1'b1);
		chk("fw lock byte change", {rsp[0], str}, 4'b1000);
		acc(fbw_pkg::FBW_OP_ERASE, fbw_pkg::FBW_SRC_DEBUG, 17'h1fb00, 8'h00, 1'b0);
		chk("debug lock page erase", {rsp, str}, 6'b010000);
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_DEBUG, fbw_pkg::RESV_BASE_ADDR, 8'h00, 1'b0);
		chk("debug reserved", {rsp, str}, 6'b010000);
		acc(fbw_pkg::FBW_OP_READ, fbw_pkg::FBW_SRC_CODE_LOCKED, fbw_pkg::RESV_BASE_ADDR, 8'h00, 1'b0);
		chk("fw reserved", rsp[0], 1'b1);
		acc(fbw_pkg::FBW_OP_DEV_ERASE, fbw_pkg::FBW_SRC_DEBUG, 17'h00000, 8'h00, 1'b0);
		chk("device erase strobe", str, 3'b001);
		rst();
		acc(fbw_pkg::FBW_OP_WRITE, fbw_pkg::FBW_SRC_DEBUG, 17'h00012, 8'h00, 1'b0);
		chk("all unlocked", rsp, 3'b100);
	endtask

	// Main sequence; later scenarios build on earlier state, t_abort on the block mode that t_block leaves on
	initial begin
		repeat (3) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		t_block();
		t_abort();
		t_keys_enables();
		t_external_move_instr();
		t_security();
		tally_and_finish();
	end
endmodule
